// ---- rtl/scdr_rx.sv ----
// Receive front end: capture, phase detector, deserializer, FIFO control
`timescale 1ns/1ps
module scdr_rx (
  input  wire logic        clock,
  input  wire logic        clk_en,
  input  wire logic        arst_n,
  input  wire logic [2:0]  mode,
  input  wire logic        ext_clk_tick,
  input  wire logic        ext_data,
  input  wire logic        ref_tick,
  input  wire logic        vco_tick,
  input  wire logic        pd_bit,
  input  wire logic        data_transition,
  input  wire logic        transition_late,
  input  wire logic [10:0] os_bits,
  input  wire logic [3:0]  os_count,
  input  wire logic        os_valid,
  output logic             os_ready,
  input  wire logic        read_tick,
  output logic [9:0]       word,
  output logic             word_valid,
  output logic             word_clk,
  output logic             speed_up_pulse,
  output logic             slow_down_pulse,
  output logic             pll_locked,
  output logic             rd_vco_faster,
  output logic             rd_vco_slow_down_pulse,
  output logic             fifo_reading
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [9:0]                ring;
    logic [9:0]                shift;
    logic [9:0]                word;
    logic                      word_valid;
    logic                      word_clk;
    logic [1:0]                input_delay_element;
    logic [2:0]                global_clock_buffer;
    logic                      input_capture_flop;
    scdr_pkg::scdr_pd_type     pd_state;
    logic [7:0]                ref_cnt;
    logic [7:0]                vco_cnt;
    logic [1:0]                vco_seen;
    logic [3:0]                lock_cnt;
    logic [7:0]                quiet_cnt;
    logic                      speed_up_pulse;
    logic                      slow_down_pulse;
    logic                      pll_locked;
    logic [19:0]               acc;
    logic [4:0]                acc_cnt;
    logic                      os_ready;
    scdr_pkg::scdr_fc_type     fc_state;
    logic                      rd_vco_faster;
    logic                      rd_vco_slow_down_pulse;
  } scdr_state_type;
  scdr_state_type st;
  scdr_state_type next_st;
  logic       mode_ext;
  logic       mode_pll;
  logic       mode_ovs;
  logic       bit_tick;
  logic       bit_val;
  logic       ref_div;
  logic       vco_div;
  logic       acc_emit;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [9:0] fifo_out_data;
  logic [3:0] fifo_level;
  logic       fifo_pop;

  assign mode_ext = (mode == scdr_pkg::SCDR_MODE_EXT);
  assign mode_pll = (mode == scdr_pkg::SCDR_MODE_PLL);
  assign mode_ovs = (mode == scdr_pkg::SCDR_MODE_OVS);
  // Bit source: re-timed capture flop, or the phase detector sample
  assign bit_tick = mode_ext ? st.global_clock_buffer[2]
                             : (mode_pll && vco_tick);
  assign bit_val  = mode_ext ? st.input_capture_flop : pd_bit;
  // Reference and VCO dividers terminal counts
  assign ref_div = ref_tick && scdr_pkg::scdr_div_hit(st.ref_cnt,
                                                       scdr_pkg::N_DIV);
  assign vco_div = vco_tick && scdr_pkg::scdr_div_hit(st.vco_cnt,
                                                       scdr_pkg::M_DIV);
  // Accumulator hands a full word to the buffer when it has room
  assign acc_emit = mode_ovs && (st.acc_cnt >= scdr_pkg::ACC_WORD);
  // Pop only where the controller takes the word, or it would be lost
  assign fifo_pop = (st.fc_state == scdr_pkg::SCDR_FC_RUN) && read_tick &&
                    fifo_out_valid && mode_ovs;

  // ****************************************************************
  // Recovered word buffer
  // ****************************************************************
  scdr_fifo #(
    .WIDTH (scdr_pkg::WORD_BITS),
    .DEPTH (scdr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .clk_en    (clk_en),
    .arst_n    (arst_n),
    .in_valid  (acc_emit),
    .in_ready  (fifo_in_ready),
    .in_data   (st.acc[9:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );
  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic [19:0] acc_t;
    logic [4:0]  cnt_t;
    logic [1:0]  seen_t;
    acc_t   = st.acc;
    cnt_t   = st.acc_cnt;
    seen_t  = st.vco_seen;
    next_st = st;
    next_st.word_valid      = 1'b0;
    next_st.speed_up_pulse  = 1'b0;
    next_st.slow_down_pulse = 1'b0;
    next_st.rd_vco_faster   = 1'b0;
    next_st.rd_vco_slow_down_pulse   = 1'b0;
    // Clock buffered on its own chain; data delayed to line up
    next_st.global_clock_buffer = {st.global_clock_buffer[1:0],
                                   ext_clk_tick};                // see R10
    next_st.input_delay_element = {st.input_delay_element[0],
                                   ext_data};                    // see R10
    next_st.input_capture_flop  = st.input_delay_element[1];     // see R10
    // Deserializer: LSB first, no boundary search here
    if (bit_tick) begin
      next_st.shift = {bit_val, st.shift[9:1]};                  // see R04
      next_st.ring  = {st.ring[8:0], st.ring[9]};   // see R05, see R18
      // Word clock high in second half so load meets its falling edge
      next_st.word_clk = |st.ring[8:4];                          // see R07
      if (st.ring[9]) begin
        next_st.word       = {bit_val, st.shift[9:1]};  // see R06, see R17
        next_st.word_valid = 1'b1;                               // see R08
      end
    end
    // Dividers by N and M
    if (ref_tick) begin
      next_st.ref_cnt = ref_div ? 8'h00 : st.ref_cnt + 8'h01;
    end
    if (vco_tick) begin
      next_st.vco_cnt = vco_div ? 8'h00 : st.vco_cnt + 8'h01;
    end
    // Phase detector
    case (st.pd_state)
      scdr_pkg::SCDR_PD_REF: begin
        if (vco_div && seen_t != 2'h3) begin
          seen_t = seen_t + 2'h1;
        end
        next_st.vco_seen = seen_t;
        if (mode_pll && ref_div) begin
          next_st.vco_seen = 2'h0;
          // One divided VCO edge per divided reference edge is balance
          if (seen_t == 2'h0) begin
            next_st.speed_up_pulse = 1'b1;               // see R01, see R09
            next_st.lock_cnt       = 4'h0;
          end else if (seen_t > 2'h1) begin
            next_st.slow_down_pulse = 1'b1;              // see R01, see R09
            next_st.lock_cnt        = 4'h0;
          end else if (st.lock_cnt == scdr_pkg::LOCK_PERIODS) begin
            next_st.pd_state   = scdr_pkg::SCDR_PD_TRACK;        // see R02
            next_st.pll_locked = 1'b1;
            next_st.quiet_cnt  = 8'h00;
          end else begin
            next_st.lock_cnt = st.lock_cnt + 4'h1;
          end
        end
      end
      scdr_pkg::SCDR_PD_TRACK: begin
        if (!mode_pll) begin
          next_st.pd_state   = scdr_pkg::SCDR_PD_REF;
          next_st.pll_locked = 1'b0;
          next_st.lock_cnt   = 4'h0;
        end else if (data_transition) begin
          next_st.quiet_cnt       = 8'h00;
          next_st.speed_up_pulse  = transition_late;             // see R09
          next_st.slow_down_pulse = !transition_late;            // see R09
        end else if (st.quiet_cnt ==
                     8'(scdr_pkg::STREAM_LOSS_CYCLES - 8'h01)) begin
          // Stream gone: reference keeps the loop near its rate
          next_st.pd_state   = scdr_pkg::SCDR_PD_REF;            // see R03
          next_st.pll_locked = 1'b0;
          next_st.lock_cnt   = 4'h0;
          next_st.vco_seen   = 2'h0;
        end else begin
          next_st.quiet_cnt = st.quiet_cnt + 8'h01;
        end
      end
      default: begin
        next_st.pd_state = scdr_pkg::SCDR_PD_REF;
      end
    endcase
    // Oversampler packing: 9 to 11 bits in, 10 out
    if (acc_emit && fifo_in_ready) begin
      acc_t = st.acc >> 10;
      cnt_t = st.acc_cnt - scdr_pkg::ACC_WORD;                   // see R13
    end
    if (mode_ovs && os_valid && st.os_ready) begin
      acc_t = acc_t | (20'(os_bits) << cnt_t);                   // see R12
      cnt_t = 5'(cnt_t + 5'(os_count));                          // see R13
    end
    next_st.acc      = acc_t;
    next_st.acc_cnt  = cnt_t;
    // Ready only while one more 11-bit group cannot overflow
    next_st.os_ready = (cnt_t < scdr_pkg::ACC_WORD);             // see R13
    // Read controller on the regenerated word clock
    case (st.fc_state)
      scdr_pkg::SCDR_FC_WAIT: begin
        if (mode_ovs && fifo_level >= scdr_pkg::FIFO_HALF) begin
          next_st.fc_state = scdr_pkg::SCDR_FC_RUN;              // see R15
        end
      end
      scdr_pkg::SCDR_FC_RUN: begin
        if (!mode_ovs || !fifo_out_valid) begin
          // Ran dry: refill to half before reading again
          next_st.fc_state = scdr_pkg::SCDR_FC_WAIT;
        end else if (read_tick) begin
          next_st.word          = fifo_out_data;                 // see R14
          next_st.word_valid    = 1'b1;
          next_st.rd_vco_faster = fifo_level > scdr_pkg::FIFO_HALF; // see R16
          next_st.rd_vco_slow_down_pulse = fifo_level < scdr_pkg::FIFO_HALF; // see R20
        end
      end
      default: begin
        next_st.fc_state = scdr_pkg::SCDR_FC_WAIT;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st          <= '0;
      st.ring     <= scdr_pkg::RING_RESET;
      st.pd_state <= scdr_pkg::SCDR_PD_REF;
      st.fc_state <= scdr_pkg::SCDR_FC_WAIT;                     // see R19
      st.os_ready <= 1'b1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // Outputs straight from flops; fifo_reading is decoded from the read controller state
  assign os_ready        = st.os_ready;
  assign word            = st.word;
  assign word_valid      = st.word_valid;
  assign word_clk        = st.word_clk;
  assign speed_up_pulse  = st.speed_up_pulse;
  assign slow_down_pulse = st.slow_down_pulse;
  assign pll_locked      = st.pll_locked;
  assign rd_vco_faster   = st.rd_vco_faster;
  assign rd_vco_slow_down_pulse   = st.rd_vco_slow_down_pulse;
  assign fifo_reading    = (st.fc_state == scdr_pkg::SCDR_FC_RUN);

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_ring_onehot;
    @(posedge clock) disable iff (!arst_n)
      $onehot(st.ring);
  endproperty
  a_ring_onehot: assert property (p_ring_onehot) // see R05
    else $error("Word divider ring is not one-hot");
  property p_load_at_wrap;
    @(posedge clock) disable iff (!arst_n)
      (clk_en && bit_tick && st.ring[9]) |=>
        (st.word_valid && st.ring[0] && !st.word_clk);
  endproperty
  a_load_at_wrap: assert property (p_load_at_wrap) // see R06
    else $error("Word not loaded on the tenth bit");
  property p_load_on_fall;
    @(posedge clock) disable iff (!arst_n)
      (clk_en && bit_tick && st.ring[9] && st.word_clk) |=>
        $fell(st.word_clk);
  endproperty
  a_load_on_fall: assert property (p_load_on_fall) // see R07
    else $error("Word load not at word clock falling edge");
  property p_ref_speed;
    @(posedge clock) disable iff (!arst_n)
      (clk_en && mode_pll && st.pd_state == scdr_pkg::SCDR_PD_REF &&
       ref_div && !vco_div && st.vco_seen == 2'h0) |=> st.speed_up_pulse;
  endproperty
  a_ref_speed: assert property (p_ref_speed) // see R01
    else $error("No speed-up with slow VCO");
  property p_lock_flag;
    @(posedge clock) disable iff (!arst_n)
      st.pll_locked == (st.pd_state == scdr_pkg::SCDR_PD_TRACK);
  endproperty
  a_lock_flag: assert property (p_lock_flag) // see R02
    else $error("Lock flag disagrees with tracking state");
  property p_loss_fallback;
    @(posedge clock) disable iff (!arst_n)
      (clk_en && st.pd_state == scdr_pkg::SCDR_PD_TRACK &&
       !data_transition &&
       st.quiet_cnt == 8'(scdr_pkg::STREAM_LOSS_CYCLES - 8'h01)) |=>
        (st.pd_state == scdr_pkg::SCDR_PD_REF && !st.pll_locked);
  endproperty
  a_loss_fallback: assert property (p_loss_fallback) // see R03
    else $error("No fallback to reference after stream loss");
  property p_pulse_excl;
    @(posedge clock) disable iff (!arst_n)
      !(st.speed_up_pulse && st.slow_down_pulse) &&
      !(st.rd_vco_faster && st.rd_vco_slow_down_pulse);
  endproperty
  a_pulse_excl: assert property (p_pulse_excl) // see R09
    else $error("Speed-up and slow-down together");
  property p_hold_reads;
    @(posedge clock) disable iff (!arst_n)
      (clk_en && st.fc_state == scdr_pkg::SCDR_FC_WAIT) |=>
        (fifo_level >= $past(fifo_level));
  endproperty
  a_hold_reads: assert property (p_hold_reads) // see R15
    else $error("FIFO read before half full");
  property p_steer_level;
    @(posedge clock) disable iff (!arst_n)
      (clk_en && fifo_pop) |=>
        (st.rd_vco_faster == ($past(fifo_level) > scdr_pkg::FIFO_HALF)) &&
        (st.rd_vco_slow_down_pulse == ($past(fifo_level) < scdr_pkg::FIFO_HALF));
  endproperty
  a_steer_level: assert property (p_steer_level) // see R16
    else $error("Read VCO steering does not follow level");
  property p_half_quiet;
    @(posedge clock) disable iff (!arst_n)
      (clk_en && fifo_pop && fifo_level == scdr_pkg::FIFO_HALF) |=>
        (!st.rd_vco_faster && !st.rd_vco_slow_down_pulse);
  endproperty
  a_half_quiet: assert property (p_half_quiet) // see R20
    else $error("Steering issued at exactly half full");
endmodule : scdr_rx

// ---- rtl/scdr_pkg.sv ----
// Constants, types and helpers shared by the serial receive front end
// Behaviour
// R01 - At start, steer VCO so VCO/M frequency matches reference/N frequency.
// R02 - After frequency lock to reference, switch to tracking the bitstream.
// R03 - On loss of bitstream, fall back to locking on the reference.
// R04 - Shift each recovered bit into a 10-bit shift register.
// R05 - Derive word-rate clock by dividing the bit-rate clock by ten.
// R06 - Divider enable loads holding register once per ten bit cycles.
// R07 - Holding register loads at the falling edge of word clock.
// R08 - Holding register output feeds the downstream descrambler and framer.
// R09 - Emit speed-up and slow-down pulses toward the integrating loop filter.
// R10 - External clock buffered globally; data delayed to match, then captured.
// R11 - External reclocker handles four rates and delivers re-timed data.
// R12 - Oversampling path needs no phase relation to local clock.
// R13 - Oversampler gives 9, 10 or 11 bits; shallow buffer absorbs it.
// R14 - Regeneration mode writes words to FIFO read by VCO word clock.
// R15 - Reads are held off until the FIFO first reaches half full.
// R16 - After start, steer read VCO to keep FIFO level near half.
// R17 - No word alignment here; downstream framer finds boundaries.
// R18 - External mode word clock comes from a divide-by-ten ring counter.
// R19 - Reset returns FIFO controller to fill-wait with reads suspended.
// R20 - At exactly half full, neither speed-up nor slow-down is issued.
package scdr_pkg;

  // ****************************************************************
  // Word and divider sizes
  // ****************************************************************
  localparam int          WORD_BITS        = 10;
  localparam logic [9:0]  RING_RESET       = 10'h001;
  localparam int          EXT_DELAY_STAGES = 2;
  localparam logic [7:0]  N_DIV            = 8'h04;
  localparam logic [7:0]  M_DIV            = 8'h28;
  localparam logic [3:0]  LOCK_PERIODS     = 4'hF;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLOCK_PERIOD_NS  = 50;
  localparam int          STREAM_LOSS_NS   = 2000;
  // Timeout is a longest time, so round down
  localparam logic [7:0]  STREAM_LOSS_CYCLES =
    8'(STREAM_LOSS_NS / CLOCK_PERIOD_NS);

  // ****************************************************************
  // Buffering
  // ****************************************************************
  localparam int          FIFO_DEPTH       = 8;
  localparam logic [3:0]  FIFO_HALF        = 4'h4;
  localparam int          ACC_BITS         = 20;
  localparam logic [4:0]  ACC_WORD         = 5'h0A;

  // ****************************************************************
  // Modes and states
  // ****************************************************************
  typedef enum logic [2:0] {
    SCDR_MODE_EXT  = 3'b001,
    SCDR_MODE_PLL  = 3'b010,
    SCDR_MODE_OVS  = 3'b100
  } scdr_mode_type;

  typedef enum logic [1:0] {
    SCDR_PD_REF    = 2'b01,
    SCDR_PD_TRACK  = 2'b10
  } scdr_pd_type;

  typedef enum logic [1:0] {
    SCDR_FC_WAIT   = 2'b01,
    SCDR_FC_RUN    = 2'b10
  } scdr_fc_type;

  // Divider step: returns one on terminal count, used for N and M
  function automatic logic scdr_div_hit(input logic [7:0] cnt,
                                        input logic [7:0] div);
    scdr_div_hit = (cnt == 8'(div - 8'h01));
  endfunction : scdr_div_hit

endpackage : scdr_pkg

// ---- rtl/scdr_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module scdr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic                       clock,
  input  wire logic                       clk_en,
  input  wire logic                       arst_n,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH):0]          level
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 level;
  } scdr_fifo_state_type;

  scdr_fifo_state_type st;
  scdr_fifo_state_type next_st;
  logic                push;
  logic                pop;

  // Flags straight from the fill count, so full and empty are exact
  assign in_ready  = (st.level != (AW+1)'(DEPTH));
  assign out_valid = (st.level != '0);
  assign out_data  = st.mem[st.rd];
  assign level     = st.level;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr         = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    if (push && !pop) begin
      next_st.level = st.level + 1'b1;
    end else if (pop && !push) begin
      next_st.level = st.level - 1'b1;
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  property p_fifo_bound;
    @(posedge clock) disable iff (!arst_n)
      st.level <= (AW+1)'(DEPTH);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) // see R13
    else $error("FIFO level beyond depth");

  property p_fifo_count;
    @(posedge clock) disable iff (!arst_n)
      (clk_en && push && !pop) |=> (st.level == $past(st.level) + 1'b1);
  endproperty
  a_fifo_count: assert property (p_fifo_count) // see R14
    else $error("FIFO level did not follow a write");

endmodule : scdr_fifo

// ---- testbench/scdr_far_end.sv ----
// Behavioural model of the reclocker, reference oscillator and VCO
`timescale 1ns/1ps
module scdr_far_end (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       send,
  input  wire logic [9:0] tx_word,
  input  wire logic       vco_run,
  output logic            ext_clk_tick,
  output logic            ext_data,
  output logic            vco_tick,
  output logic            ref_tick,
  output logic            busy
);
  logic [9:0] shift;
  logic [3:0] left;
  logic [3:0] ref_cnt;

  // ****************************************************************
  // Reference every 10 cycles; running VCO ticks every cycle
  // ****************************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {shift, left, ref_cnt} <= '0;
      {ext_clk_tick, ext_data, vco_tick, ref_tick} <= '0;
    end else begin
      ref_cnt  <= (ref_cnt == 4'h9) ? 4'h0 : ref_cnt + 4'h1;
      ref_tick <= (ref_cnt == 4'h9);
      vco_tick <= vco_run;
      if (send && left == 4'h0) begin
        shift        <= tx_word;
        left         <= 4'hA;
        ext_clk_tick <= 1'b0;
      end else if (left != 4'h0) begin
        // Data leaves re-timed to its own tick, LSB first
        ext_clk_tick <= 1'b1;
        ext_data     <= shift[0];
        shift        <= shift >> 1;
        left         <= left - 4'h1;
      end else begin
        // Idle line is not held: stale data would hide capture slips
        ext_clk_tick <= 1'b0;
        ext_data     <= ~ext_data;
      end
    end
  end

  assign busy = (left != 4'h0);
endmodule : scdr_far_end

// ---- testbench/sdi_rx_clock_data_recovery_tb.sv ----
// Self-checking bench for the serial receive front end
`timescale 1ns/1ps
module sdi_rx_clock_data_recovery_tb;
  logic        clock, arst_n, clk_en, send, vco_run, watch, seen;
  logic        ext_clk_tick, ext_data, vco_tick, ref_tick, busy;
  logic        data_transition, transition_late, os_valid, os_ready;
  logic        read_tick, word_valid, word_clk, speed_up_pulse;
  logic        slow_down_pulse, pll_locked, rd_vco_faster;
  logic        rd_vco_slow_down_pulse, fifo_reading;
  logic [2:0]  mode;
  logic [9:0]  tx_word, word, w;
  logic [10:0] os_bits;
  logic [3:0]  os_count;
  logic [49:0] strm;
  logic [9:0]  exp_q[$];
  int          miscompares, n_tests, off, i;
  int          grp[5] = '{9, 11, 10, 10, 10};
  logic [1:0]  pace[5] = '{2'b10, 2'b00, 2'b01, 2'b01, 2'b01};

  scdr_rx uut (.clock(clock), .clk_en(clk_en), .arst_n(arst_n), .mode(mode),
    .ext_clk_tick(ext_clk_tick), .ext_data(ext_data), .ref_tick(ref_tick),
    .vco_tick(vco_tick), .pd_bit(ext_data),
    .data_transition(data_transition), .transition_late(transition_late),
    .os_bits(os_bits), .os_count(os_count), .os_valid(os_valid),
    .os_ready(os_ready), .read_tick(read_tick), .word(word),
    .word_valid(word_valid), .word_clk(word_clk),
    .speed_up_pulse(speed_up_pulse), .slow_down_pulse(slow_down_pulse),
    .pll_locked(pll_locked), .rd_vco_faster(rd_vco_faster),
    .rd_vco_slow_down_pulse(rd_vco_slow_down_pulse), .fifo_reading(fifo_reading));

  scdr_far_end far (.clock(clock), .arst_n(arst_n), .send(send),
    .tx_word(tx_word), .vco_run(vco_run), .ext_clk_tick(ext_clk_tick),
    .ext_data(ext_data), .vco_tick(vco_tick), .ref_tick(ref_tick),
    .busy(busy));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [9:0] got, input logic [9:0] exp_v);
    n_tests++;
    if (got !== exp_v) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp_v);
    end
  endtask : check

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    #1;
    check(10'({pll_locked, fifo_reading}), 10'h000);
  endtask : do_reset

  // Request held for one cycle, in which the idle model takes it; then wait until it has finished the word
  task automatic ext_word(input logic [9:0] v);
    @(posedge clock);
    send <= 1'b1;
    tx_word <= v;
    exp_q.push_back(v);
    @(posedge clock);
    send <= 1'b0;
    @(posedge clock);
    while (busy === 1'b1) @(posedge clock);
  endtask : ext_word

  task automatic os_send(input logic [10:0] b, input logic [3:0] c);
    @(posedge clock);
    os_bits <= b;
    os_count <= c;
    os_valid <= 1'b1;
    @(posedge clock);
    while (os_ready !== 1'b1) @(posedge clock);
    os_valid <= 1'b0;
  endtask : os_send

  task automatic rd_once();
    @(posedge clock);
    read_tick <= 1'b1;
    @(posedge clock);
    read_tick <= 1'b0;
    #1;
  endtask : rd_once

  // Clock, 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Oldest note is matched against each new word
  always @(posedge clock) begin
    if (watch && word_valid === 1'b1) begin
      if (exp_q.size() == 0) check(word, ~word);
      else check(word, exp_q.pop_front());
      if (mode == 3'b001) check(10'(word_clk), 10'h000);
    end
  end

  // Hang guard, well past the longest expected run
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    test_done();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {arst_n, send, vco_run, watch, data_transition, transition_late} = '0;
    {os_valid, read_tick, mode, tx_word, os_bits, os_count} = '0;
    miscompares = 0;
    clk_en = 1'b1;
    n_tests = 0;
    void'($urandom(32'h955B));
    do_reset();
    mode <= 3'b001;
    watch <= 1'b1;
    repeat (3) ext_word(10'($urandom));
    repeat (8) @(posedge clock);
    check(10'(exp_q.size()), 10'h000);
    $display("external reclocker test done");

    do_reset();
    mode <= 3'b100;
    for (i = 0; i < 5; i++) begin
      w = 10'($urandom);
      strm[i*10 +: 10] = w;
      exp_q.push_back(w);
    end
    off = 0;
    // Group sizes of 9 and 11 straddle word boundaries
    for (i = 0; i < 5; i++) begin
      os_send(11'((strm >> off) & ((50'h1 << grp[i]) - 50'h1)), 4'(grp[i]));
      off += grp[i];
      if (i == 1) begin
        // Twenty bits pending: no room for another group
        #1;
        check(10'(os_ready), 10'h000);
        repeat (4) @(posedge clock);
        check(10'(fifo_reading), 10'h000);
      end
    end
    repeat (5) @(posedge clock);
    #1;
    check(10'(fifo_reading), 10'h001);
    for (i = 0; i < 5; i++) begin
      rd_once();
      check(10'({rd_vco_faster, rd_vco_slow_down_pulse}), 10'(pace[i]));
    end
    repeat (4) @(posedge clock);
    check(10'(fifo_reading), 10'h000);
    check(10'(exp_q.size()), 10'h000);
    $display("oversampling test done");

    do_reset();
    watch <= 1'b0;
    mode <= 3'b010;
    seen = 1'b0;
    repeat (100) begin
      @(posedge clock);
      if (speed_up_pulse === 1'b1) seen = 1'b1;
    end
    check(10'(seen), 10'h001);
    vco_run <= 1'b1;
    for (i = 0; i < 1000 && pll_locked !== 1'b1; i++) @(posedge clock);
    check(10'(pll_locked), 10'h001);
    for (i = 0; i < 2; i++) begin
      @(posedge clock);
      data_transition <= 1'b1;
      transition_late <= (i == 0);
      @(posedge clock);
      data_transition <= 1'b0;
      #1;
      check(10'({speed_up_pulse, slow_down_pulse}), 10'(2 - i));
    end
    // Frozen cycles must not count toward stream loss
    clk_en <= 1'b0;
    repeat (10) @(posedge clock);
    clk_en <= 1'b1;
    repeat (35) @(posedge clock);
    #1;
    check(10'(pll_locked), 10'h001);
    repeat (10) @(posedge clock);
    #1;
    check(10'(pll_locked), 10'h000);
    $display("phase detector test done");
    test_done();
  end
endmodule : sdi_rx_clock_data_recovery_tb
